// [design/dma_device.sv]
// device end: mode register bank and eight ramping digital attenuators
// assumes fs_tick_i is a one-cycle strobe per sample, on clk_sys_i
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module dma_device #(
  parameter int unsigned STEP_SAMPLES = dma_pkg::STEP_FS
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_i,
  dma_link_if.device                     link,
  input  wire logic                      fs_tick_i,
  output logic [dma_pkg::NUM_CH*8-1:0]   channel_attenuation_code_o,
  output logic [dma_pkg::NUM_CH*8-1:0]   applied_level_o,
  output logic [dma_pkg::NUM_CH-1:0]     channel_muted_o,
  output logic [dma_pkg::NUM_CH-1:0]     channel_output_disable_o,
  output logic [5:0]                     format_filter_clock_o,
  output logic [6:0]                     deemphasis_phase_flag_o,
  output logic [7:0]                     oversampling_gpo_o
);
  import dma_pkg::*;

  // the pacer counts in eight bits, so the step length must fit in it
  if (STEP_SAMPLES < 1 || STEP_SAMPLES > 256) begin : g_bad_step
    $error("STEP_SAMPLES out of range");
  end

  logic [7:0] att_q [NUM_CH];
  logic [7:0] lvl_q [NUM_CH];
  logic [NUM_CH-1:0] mute_q;
  logic [NUM_CH-1:0] dis_q;
  logic [7:0] cfg9_q;
  logic [7:0] cfg10_q;
  logic [7:0] rdctl_q;
  logic [7:0] cfg12_q;
  logic [6:0] rd_ptr_q;
  logic [7:0] fs_cnt_q;
  logic       step_q;
  logic       rd_valid_q;
  logic [7:0] rd_data_q;

  logic       wr_en;
  logic       rd_en;
  logic [6:0] idx;
  logic [7:0] wdata;

  // word decode
  assign rd_en = link.word_valid & link.word[RW_BIT];
  assign wr_en = link.word_valid & ~link.word[RW_BIT];
  assign idx   = link.word[IDX_MSB:IDX_LSB];
  assign wdata = link.word[DATA_MSB:0];

  // next index of a sequential read: skips the reserved gap, wraps after 13h
  function automatic logic [6:0] next_idx(input logic [6:0] i);
    if (i == IDX_DIS_HI) begin
      return IDX_FIRST;
    end else if (i == IDX_HOLE_LO) begin
      return IDX_HOLE_HI;
    end else begin
      return 7'(i + 7'h01);
    end
  endfunction

  // read mux; reserved bits read back zero
  function automatic logic [7:0] read_reg(input logic [6:0] i);
    logic [7:0] r;
    r = 8'h00;
    for (int c = 0; c < NUM_CH; c++) begin
      if (i == ATT_IDX[c]) begin
        r = att_q[c];
      end
    end
    unique case (i)
      IDX_MUTE_LO: r = {2'b00, mute_q[5:0]};
      IDX_DIS_LO:  r = {2'b00, dis_q[5:0]};
      IDX_CFG9:    r = cfg9_q;
      IDX_CFG10:   r = cfg10_q;
      IDX_RDCTL:   r = rdctl_q;
      IDX_CFG12:   r = cfg12_q;
      IDX_MUTE_HI: r = {6'b000000, mute_q[7:6]};
      IDX_DIS_HI:  r = {6'b000000, dis_q[7:6]};
      default:     r = r;
    endcase
    return r;
  endfunction

  // attenuation code storage, one generate slot per channel
  for (genvar c = 0; c < NUM_CH; c++) begin : g_att
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        att_q[c] <= ATT_RESET;
      end else if (wr_en && idx == ATT_IDX[c]) begin
        att_q[c] <= wdata;
      end
    end
  end

  // control and configuration bits; other indices fall through untouched
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mute_q  <= '0;
      dis_q   <= '0;
      cfg9_q  <= CFG_RESET;
      cfg10_q <= CFG_RESET;
      rdctl_q <= RDCTL_RESET;
      cfg12_q <= CFG_RESET;
    end else if (wr_en) begin
      unique case (idx)
        IDX_MUTE_LO: mute_q[5:0] <= wdata[5:0];
        IDX_MUTE_HI: mute_q[7:6] <= wdata[1:0];
        IDX_DIS_LO:  dis_q[5:0]  <= wdata[5:0];
        IDX_DIS_HI:  dis_q[7:6]  <= wdata[1:0];
        IDX_CFG9:    cfg9_q  <= wdata & MASK_CFG9;
        IDX_CFG10:   cfg10_q <= wdata & MASK_CFG10;
        IDX_RDCTL:   rdctl_q <= wdata;
        IDX_CFG12:   cfg12_q <= wdata;
        default:     ;
      endcase
    end
  end

  // read answer one cycle after the word, pointer walks only with increment on
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_ptr_q   <= RDCTL_RESET[6:0];
      rd_valid_q <= 1'b0;
      rd_data_q  <= 8'h00;
    end else begin
      rd_valid_q <= rd_en;
      if (wr_en && idx == IDX_RDCTL) begin
        rd_ptr_q <= wdata[6:0];
      end else if (rd_en) begin
        rd_data_q <= read_reg(rdctl_q[RD_INC_BIT] ? rd_ptr_q : rdctl_q[6:0]);
        if (rdctl_q[RD_INC_BIT]) begin
          rd_ptr_q <= next_idx(rd_ptr_q);
        end
      end
    end
  end

  // shared step pacer: one step pulse every STEP_SAMPLES sample strobes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fs_cnt_q <= 8'h00;
      step_q   <= 1'b0;
    end else begin
      step_q <= 1'b0;
      if (fs_tick_i) begin
        if (fs_cnt_q == 8'(STEP_SAMPLES - 1)) begin
          fs_cnt_q <= 8'h00;
          step_q   <= 1'b1;
        end else begin
          fs_cnt_q <= 8'(fs_cnt_q + 8'h01);
        end
      end
    end
  end

  // per-channel ramp; level 128 stands for infinite attenuation
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ramp
    logic [7:0] target;
    // mute ramps to 128 rather than jumping, to avoid a click
    assign target = (mute_q[c] || att_q[c] <= ATT_MUTE) ? ATT_MUTE : att_q[c];
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        lvl_q[c] <= ATT_RESET;
      end else if (step_q) begin
        if (lvl_q[c] < target) begin
          lvl_q[c] <= 8'(lvl_q[c] + 8'h01);
        end else if (lvl_q[c] > target) begin
          lvl_q[c] <= 8'(lvl_q[c] - 8'h01);
        end
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      channel_attenuation_code_o <= {NUM_CH{ATT_RESET}};
      applied_level_o            <= {NUM_CH{ATT_RESET}};
      channel_muted_o            <= '0;
      channel_output_disable_o   <= '0;
      format_filter_clock_o      <= '0;
      deemphasis_phase_flag_o    <= '0;
      oversampling_gpo_o         <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        channel_attenuation_code_o[c*8 +: 8] <= att_q[c];
        applied_level_o[c*8 +: 8]            <= lvl_q[c];
        channel_muted_o[c] <= (lvl_q[c] <= ATT_MUTE);
      end
      channel_output_disable_o <= dis_q;
      format_filter_clock_o    <= cfg9_q[5:0];
      deemphasis_phase_flag_o  <= cfg10_q[6:0];
      oversampling_gpo_o       <= cfg12_q;
    end
  end

  assign link.rd_valid = rd_valid_q;
  assign link.rd_data  = rd_data_q;

endmodule

// [design/dma_pkg.sv]
// shared constants for the dac mode register bank and its host end
// assumes one 200 MHz clock and a sample-rate strobe from the audio path
package dma_pkg;

  localparam int unsigned NUM_CH      = 8;
  localparam int unsigned STEP_FS     = 8;          // sample periods per 0.5 dB step
  localparam int unsigned CLK_PERIOD_NS = 5;

  // control word layout
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned RW_BIT      = 15;
  localparam int unsigned IDX_MSB     = 14;
  localparam int unsigned IDX_LSB     = 8;
  localparam int unsigned DATA_MSB    = 7;

  // register indices
  localparam logic [6:0] IDX_MUTE_LO  = 7'h07;
  localparam logic [6:0] IDX_DIS_LO   = 7'h08;
  localparam logic [6:0] IDX_CFG9     = 7'h09;
  localparam logic [6:0] IDX_CFG10    = 7'h0A;
  localparam logic [6:0] IDX_RDCTL    = 7'h0B;
  localparam logic [6:0] IDX_CFG12    = 7'h0C;
  localparam logic [6:0] IDX_MUTE_HI  = 7'h12;
  localparam logic [6:0] IDX_DIS_HI   = 7'h13;
  localparam logic [6:0] IDX_FIRST    = 7'h01;
  localparam logic [6:0] IDX_HOLE_LO  = 7'h0C;     // last before the reserved gap
  localparam logic [6:0] IDX_HOLE_HI  = 7'h10;     // first after the reserved gap
  localparam logic [6:0] ATT_IDX [NUM_CH] = '{7'h01, 7'h02, 7'h03, 7'h04,
                                              7'h05, 7'h06, 7'h10, 7'h11};

  // attenuation codes
  localparam logic [7:0] ATT_RESET    = 8'hFF;
  localparam logic [7:0] ATT_MUTE     = 8'h80;     // 128 and below: infinite

  // reset values and field masks
  localparam logic [7:0] RDCTL_RESET  = 8'h01;     // index 01h, auto-increment off
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [7:0] MASK_CFG9    = 8'h3F;
  localparam logic [7:0] MASK_CFG10   = 8'h7F;
  localparam logic [7:0] MASK_LO6     = 8'h3F;
  localparam logic [7:0] MASK_HI2     = 8'h03;
  localparam int unsigned RD_INC_BIT  = 7;

  // host-end APB register byte addresses
  localparam logic [7:0] APB_CMD      = 8'h00;
  localparam logic [7:0] APB_STATUS   = 8'h04;
  localparam logic [7:0] APB_RDATA    = 8'h08;

endpackage

// [design/dma_link_if.sv]
// link carrying 16-bit control words from host end to device end
// assumes both ends share clk_sys_i; no clocking block by design
`timescale 1ns/1ps
interface dma_link_if;
  logic        word_valid;   // one-cycle pulse, word taken on that edge
  logic [15:0] word;         // b15 read flag, b14..b8 index, b7..b0 data
  logic        rd_valid;     // one-cycle pulse answering a read
  logic [7:0]  rd_data;

  modport device (input word_valid, input word, output rd_valid, output rd_data);
  modport host   (output word_valid, output word, input rd_valid, input rd_data);
endinterface

// [design/dma_host.sv]
// host end: apb slave that issues control words and collects read answers
// assumes the device answers each read within a few cycles on the same clock
`timescale 1ns/1ps
module dma_host (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  dma_link_if.host         link
);
  import dma_pkg::*;

  logic        busy_q;
  logic        rd_done_q;
  logic [7:0]  rd_data_q;
  logic        word_valid_q;
  logic [15:0] word_q;
  logic        access;
  logic        mapped;

  // second access cycle completes: pready is registered
  assign access = psel_i & penable_i & pready_o;
  assign mapped = (paddr_i == APB_CMD) | (paddr_i == APB_STATUS) | (paddr_i == APB_RDATA);

  // apb answer, one wait state so prdata can come from a flop
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~mapped;
      prdata_o  <= 32'h0000_0000;
      if (psel_i && penable_i && !pready_o && !pwrite_i) begin
        unique case (paddr_i)
          APB_CMD:    prdata_o <= {16'h0000, word_q};
          APB_STATUS: prdata_o <= {30'h0000_0000, rd_done_q, busy_q};
          APB_RDATA:  prdata_o <= {24'h00_0000, rd_data_q};
          default:    prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // command launch; a write while a read is outstanding is dropped
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      word_valid_q <= 1'b0;
      word_q       <= 16'h0000;
      busy_q       <= 1'b0;
    end else begin
      word_valid_q <= 1'b0;
      if (access && pwrite_i && paddr_i == APB_CMD && !busy_q) begin
        word_q       <= pwdata_i[15:0];
        word_valid_q <= 1'b1;
        busy_q       <= pwdata_i[RW_BIT];
      end else if (link.rd_valid) begin
        busy_q <= 1'b0;
      end
    end
  end

  // read capture; the answer sets done over any clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd_done_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else if (link.rd_valid) begin
      rd_done_q <= 1'b1;
      rd_data_q <= link.rd_data;
    end else if (access && pwrite_i && paddr_i == APB_CMD && !busy_q) begin
      rd_done_q <= 1'b0;
    end
  end

  assign link.word_valid = word_valid_q;
  assign link.word       = word_q;

endmodule

// [test/dma_link_properties.sv]
// link checker: control-word protocol and stored-value checks
// assumes it sits beside the one link joining host end and device end
`timescale 1ns/1ps
module dma_link_properties
  import dma_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic        word_valid,
  input wire logic [15:0] word,
  input wire logic        rd_valid,
  input wire logic [7:0]  rd_data
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [7:0] shd_q [128];
  // stored bits per index; unmapped indices keep an empty mask
  function automatic logic [7:0] msk(input int i);
    case (i)
      1, 2, 3, 4, 5, 6, 11, 12, 16, 17: msk = 8'hFF;
      7, 8, 9: msk = MASK_LO6;
      10: msk = MASK_CFG10;
      18, 19: msk = MASK_HI2;
      default: msk = 8'h00;
    endcase
  endfunction
  // shadow of the bank, fed only by write words seen on the link
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < 128; i++) begin
      if (rst_i)
        shd_q[i] <= (i == 11) ? RDCTL_RESET : (msk(i) == 8'hFF && i != 12) ? ATT_RESET : 8'h00;
      else if (word_valid && !word[15] && word[14:8] == 7'(i))
        shd_q[i] <= word[7:0] & msk(i);
    end
  end
  sequence s_rd_req; word_valid && word[15]; endsequence
  sequence s_answer; rd_valid ##1 !rd_valid; endsequence
  property p_read_answer; s_rd_req |=> rd_valid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_host_waits; s_rd_req |=> !word_valid throughout s_answer; endproperty
  a_host_waits: assert property (p_host_waits) else $error("word during read");
  property p_write_silent; word_valid && !word[15] |=> !rd_valid; endproperty
  a_write_silent: assert property (p_write_silent) else $error("write answered");
  property p_answer_cause; $rose(rd_valid) |-> $past(word_valid && word[15]); endproperty
  a_answer_cause: assert property (p_answer_cause) else $error("stray answer");
  property p_rd_hold; !rd_valid |-> $stable(rd_data); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  // single mode: answer is the register at the read index
  property p_read_value;
    word_valid && word[15] && !shd_q[11][7] |=> rd_data == $past(shd_q[shd_q[11][6:0]]);
  endproperty
  a_read_value: assert property (p_read_value) else $error("read data wrong");
  property p_valid_pulse; word_valid |=> !word_valid [*2]; endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("word pulse too long");
  property p_word_holds; !word_valid |-> $stable(word); endproperty
  a_word_holds: assert property (p_word_holds) else $error("word moved while idle");
  c_read: cover property (s_rd_req ##1 s_answer);
endmodule

// [test/dac_mode_register_bank_attenuator_bench.sv]
// bench: apb host end driving the device end over the link
// assumes one 200 MHz clock; ramp pace shortened to two samples a step
`timescale 1ns/1ps
module dac_mode_register_bank_attenuator_bench;
  import dma_pkg::*;
  localparam int STEP = 2;
  localparam int LIM  = 3000;
  localparam logic [6:0] IXS [16] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07,
    7'h08, 7'h09, 7'h0A, 7'h0B, 7'h0C, 7'h10, 7'h11, 7'h12, 7'h13};
  localparam logic [7:0] PATS [16] = '{8'hF1, 8'hE2, 8'hD3, 8'hC4, 8'hB5, 8'hA6, 8'h2A,
    8'h15, 8'h2D, 8'h5B, 8'h0B, 8'hA9, 8'h97, 8'h88, 8'h02, 8'h01};
  localparam logic [6:0] WALK [6] = '{7'h0C, 7'h10, 7'h11, 7'h12, 7'h13, 7'h01};
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic        fs_tick   = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic        pready, pslverr, err;
  logic [31:0] prdata, rd;
  logic [63:0] codes, lvl;
  logic [7:0]  muted, dis, gpo, v;
  logic [5:0]  ffc;
  logic [6:0]  dpf;
  logic [7:0]  exp_q [128];
  int          cyc = 0;
  int          n_errors = 0;
  int          n_compared = 0;
  dma_link_if dma_link_if_i ();
  dma_device #(.STEP_SAMPLES(STEP)) dma_device_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .link(dma_link_if_i), .fs_tick_i(fs_tick), .channel_attenuation_code_o(codes),
    .applied_level_o(lvl), .channel_muted_o(muted), .channel_output_disable_o(dis),
    .format_filter_clock_o(ffc), .deemphasis_phase_flag_o(dpf), .oversampling_gpo_o(gpo));
  dma_host dma_host_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .link(dma_link_if_i));
  dma_link_properties dma_link_properties_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .word_valid(dma_link_if_i.word_valid), .word(dma_link_if_i.word),
    .rd_valid(dma_link_if_i.rd_valid), .rd_data(dma_link_if_i.rd_data));
  // clock
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // sample strobe every fourth cycle, so a step takes STEP*4 cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    fs_tick <= (cyc % 4 == 3);
  end
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [95:0] got, input logic [95:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      n_errors++;
      print_verdict;
    end
  endtask
  task automatic dev_write(input logic [6:0] ix, input logic [7:0] d);
    exp_q[ix] = d;
    apb(1'b1, APB_CMD, {16'h0, 1'b0, ix, d});
  endtask
  // read word, wait for the answer, then collect it
  task automatic fetch(output logic [7:0] r);
    int n;
    apb(1'b1, APB_CMD, 32'h0000_8000);
    n = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    if (rd[0] !== 1'b0) begin
      n_errors++;
      print_verdict;
    end
    check(rd[1:0], 2'b10);
    apb(1'b0, APB_RDATA, 32'h0);
    r = rd[7:0];
  endtask
  task automatic wait_lvl(input int ch, input logic [7:0] val);
    int n;
    n = 0;
    while (lvl[ch*8 +: 8] !== val && n < LIM) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n == LIM) begin
      n_errors++;
      print_verdict;
    end
  endtask
  // main sequence
  initial begin
    int t0;
    for (int i = 0; i < 128; i++)
      exp_q[i] = (7'(i) inside {ATT_IDX}) ? ATT_RESET : (i == 11) ? RDCTL_RESET : CFG_RESET;
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    check({codes ^ lvl, muted, dis}, 80'h0);
    check(lvl, {8{ATT_RESET}});
    for (int k = 0; k < 16; k++) begin
      dev_write(IDX_RDCTL, {1'b0, IXS[k]});
      fetch(v);
      check(v, exp_q[IXS[k]]);
    end
    dev_write(7'h01, 8'hFC);
    for (int s = 1; s < 4; s++) begin
      wait_lvl(0, 8'hFF - 8'(s));
      if (s > 1) check(cyc - t0, STEP * 4);
      t0 = cyc;
    end
    dev_write(7'h02, 8'h40);
    dev_write(IDX_MUTE_LO, 8'h01);
    wait_lvl(0, ATT_MUTE);
    wait_lvl(1, ATT_MUTE);
    repeat (40) @(posedge clk_sys_i);
    check({lvl[15:0], muted[1:0]}, {ATT_MUTE, ATT_MUTE, 2'b11});
    dev_write(IDX_MUTE_LO, 8'h00);
    wait_lvl(0, 8'hFC);
    repeat (40) @(posedge clk_sys_i);
    check({lvl[7:0], muted[1:0]}, {8'hFC, 2'b10});
    for (int k = 0; k < 16; k++)
      dev_write(IXS[k], PATS[k]);
    for (int k = 0; k < 16; k++) begin
      dev_write(IDX_RDCTL, {1'b0, IXS[k]});
      fetch(v);
      check(v, exp_q[IXS[k]]);
    end
    check(codes, {PATS[13], PATS[12], PATS[5], PATS[4], PATS[3], PATS[2], PATS[1], PATS[0]});
    check(dis, {PATS[15][1:0], PATS[7][5:0]});
    check({ffc, dpf, gpo}, {PATS[8][5:0], PATS[9][6:0], PATS[11]});
    apb(1'b1, 8'h21, 32'h0);
    check(err, 1'b1);
    dev_write(7'h21, 8'h00);
    dev_write(7'h53, 8'h00);
    check({codes, dis}, {PATS[13], PATS[12], PATS[5], PATS[4], PATS[3], PATS[2], PATS[1],
      PATS[0], PATS[15][1:0], PATS[7][5:0]});
    apb(1'b0, 8'h0C, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    dev_write(IDX_RDCTL, 8'h8C);
    for (int k = 0; k < 6; k++) begin
      fetch(v);
      check(v, exp_q[WALK[k]]);
    end
    print_verdict;
  end
endmodule
